// ---- common/atair_pkg.sv ----
package atair_pkg;

  // ****************************************************************
  // task file addresses
  // ****************************************************************
  localparam logic [3:0] ADDR_DATA     = 4'h0;
  localparam logic [3:0] ADDR_SUBCMD   = 4'h1;  // error on read
  localparam logic [3:0] ADDR_XFER_CNT = 4'h2;
  localparam logic [3:0] ADDR_START_SN = 4'h3;
  localparam logic [3:0] ADDR_TRK_LO   = 4'h4;
  localparam logic [3:0] ADDR_TRK_HI   = 4'h5;
  localparam logic [3:0] ADDR_UNIT_HD  = 4'h6;
  localparam logic [3:0] ADDR_CMD      = 4'h7;  // status on read
  localparam logic [3:0] ADDR_DEV_CTL  = 4'he;  // alt status on read

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ST_BSY_BIT   = 7;
  localparam int ST_DRDY_BIT  = 6;
  localparam int ST_DSC_BIT   = 4;
  localparam int ST_DRQ_BIT   = 3;
  localparam int ST_ERR_BIT   = 0;
  localparam int UH_DRIVE_BIT = 4;
  localparam int DC_SRST_BIT  = 2;
  localparam int DC_NIEN_BIT  = 1;

  // ****************************************************************
  // opcodes, word indices and fixed words
  // ****************************************************************
  localparam logic [7:0]  OPC_QUERY     = 8'hec;
  localparam logic [7:0]  LAST_WORD     = 8'hff;
  localparam logic [15:0] W_GEN_CFG     = 16'h044a;
  localparam logic [15:0] W_BUF_TYPE    = 16'h0002;
  localparam logic [15:0] W_MULTI_MAX   = 16'h8001;
  localparam logic [15:0] W_CAPS        = 16'h0b00;
  localparam logic [15:0] W_PIO_MODE    = 16'h0200;
  localparam logic [15:0] W_VALID       = 16'h0007;
  localparam logic [7:0]  W_MULTI_FLAG  = 8'h01;
  localparam logic [7:0]  W_DMA_SUPP    = 8'h07;
  localparam logic [15:0] W_ADV_PIO     = 16'h0003;
  localparam logic [15:0] W_CYCLE_TIME  = 16'h0078;
  localparam logic [15:0] W_MAJOR_VER   = 16'h007e;
  localparam logic [15:0] W_MINOR_VER   = 16'h0019;
  localparam logic [15:0] W_FEAT_82     = 16'h706b;
  localparam logic [15:0] W_FEAT_83     = 16'h400c;
  localparam logic [15:0] W_FEAT_84     = 16'h4000;
  localparam logic [7:0]  W_UDMA_SUPP   = 8'h1f;
  localparam logic [3:0]  W_TIMING_LOW  = 4'h2;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int PREP_TIME_NS  = 20;  // least busy time before data
  localparam int PREP_CYCLES   =
    (PREP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PREP_LAST = 4'(PREP_CYCLES - 1);

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef enum {ST_IDLE, ST_PREP, ST_XFER} atair_state_t;

  typedef struct packed {
    logic [15:0]  def_cyl;
    logic [15:0]  def_heads;
    logic [15:0]  def_spt;
    logic [31:0]  total_sectors;
    logic [15:0]  cur_cyl;
    logic [15:0]  cur_heads;
    logic [15:0]  cur_spt;
    logic [79:0]  serial_user;
    logic [79:0]  unique_id;
    logic [63:0]  fw_rev;
    logic [319:0] model;
    logic [7:0]   multi_count;
    logic [7:0]   dma_select;
    logic [47:0]  feat_enabled;
    logic [7:0]   udma_select;
    logic [15:0]  erase_time;
    logic [15:0]  erase_time_enh;
    logic [15:0]  security_status;
    logic [11:0]  adv_timing;
  } atair_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } atair_cmd_t;

endpackage : atair_pkg

// ---- test/atair_checker.sv ----
`timescale 1ns/1ps
module atair_checker
  import atair_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // task file port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rd_data,
  // settings and outputs
  input wire atair_cfg_t  cfg,
  input wire logic        unit_select,
  input wire logic        host_irq,
  input wire atair_cmd_t  cmd_out
);
  // ********************
  // shadow state
  // ********************
  logic       drv_reg;
  logic       nien_reg;
  logic       srst_reg;
  logic       act_reg;
  logic [8:0] cnt_reg;
  logic       acc;
  logic       dat;
  logic       rsv;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // query taken: own drive, idle, not held in reset
  assign acc = wr_stb && addr == ADDR_CMD && wr_data[7:0] == OPC_QUERY &&
               drv_reg == unit_select && !act_reg && !srst_reg;
  // data reads only count once a block runs; the host waits for drq
  assign dat = rd_stb && addr == ADDR_DATA && act_reg;
  assign rsv = cnt_reg inside {2, 4, 48, 50, 52, 62, [69:79], [91:127],
                               [129:162], [164:255]};

  // copies of the registers that acceptance and the interrupt depend on
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      drv_reg  <= 1'b0;
      nien_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else if (wr_stb && addr == ADDR_UNIT_HD) begin
      drv_reg <= wr_data[UH_DRIVE_BIT];
    end else if (wr_stb && addr == ADDR_DEV_CTL) begin
      nien_reg <= wr_data[DC_NIEN_BIT];
      srst_reg <= wr_data[DC_SRST_BIT];
    end
  end

  // word pointer; software reset drops a running block
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      act_reg <= 1'b0;
      cnt_reg <= 9'h000;
    end else if (srst_reg) begin
      act_reg <= 1'b0;
    end else if (acc) begin
      act_reg <= 1'b1;
      cnt_reg <= 9'h000;
    end else if (dat) begin
      act_reg <= cnt_reg != 9'h0ff;
      cnt_reg <= cnt_reg + 9'h001;
    end
  end

  // ********************
  // assertions
  // ********************
  AST_RD_QUIET: assert property (!rd_stb |=> rd_data == ZERO_WORD)
    else $error("read data seen without a read");
  AST_CMD_PULSE: assert property (cmd_out.valid |=> !cmd_out.valid)
    else $error("command pulse longer than one cycle");
  AST_CMD_ECHO: assert property (cmd_out.valid |-> $past(wr_stb) &&
    $past(addr) == ADDR_CMD && cmd_out.opcode == $past(wr_data[7:0]))
    else $error("forwarded command without its write");
  AST_QUERY_LOCAL: assert property (acc |=> !cmd_out.valid)
    else $error("query opcode forwarded");
  AST_QUERY_IRQ: assert property (acc && !nien_reg
    |-> ##[5:8] host_irq) else $error("no interrupt after query");
  AST_IRQ_ACK: assert property (host_irq && rd_stb &&
    addr == ADDR_CMD |-> ##[1:3] !host_irq)
    else $error("interrupt kept after status read");
  AST_WORD0: assert property (dat && cnt_reg == 9'h000 |=>
    rd_data == W_GEN_CFG) else $error("word 0 wrong");
  AST_SECTORS: assert property (dat && cnt_reg == 9'h007 |=>
    rd_data == cfg.total_sectors[31:16]) else $error("word 7 wrong");
  AST_BUF_TYPE: assert property (dat && cnt_reg == 9'h014 |=>
    rd_data == W_BUF_TYPE) else $error("word 20 wrong");
  AST_MULTI: assert property (dat && cnt_reg == 9'h02f |=>
    rd_data == W_MULTI_MAX) else $error("word 47 wrong");
  AST_RESERVED: assert property (dat && rsv |=>
    rd_data == ZERO_WORD) else $error("reserved word not zero");
endmodule : atair_checker

bind atair_responder atair_checker u_atair_checker (
  .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
  .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rd_data(rd_data), .cfg(cfg), .unit_select(unit_select),
  .host_irq(host_irq), .cmd_out(cmd_out)
);

// ---- test/atair_host_model.sv ----
`timescale 1ns/1ps
module atair_host_model
  import atair_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // task file port
  output logic      [3:0]  addr,
  output logic      [15:0] wr_data,
  output logic             wr_stb,
  output logic             rd_stb,
  input  wire logic [15:0] rd_data
);
  // ********************
  // bus cycles
  // ********************
  initial begin
    addr    = 4'h0;
    wr_data = 16'h0000;
    wr_stb  = 1'b0;
    rd_stb  = 1'b0;
  end

  // one write; a quiet cycle follows so a strobe never re-arms in a step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge ref_clk);
    wr_stb  <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  // one read; data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
    @(posedge ref_clk);
  endtask : rd

  // select a drive with random head bits, then start the query
  task automatic query(input logic drv);
    wr(ADDR_UNIT_HD, {8'h00, 3'h5, drv, 4'($urandom)});
    wr(ADDR_CMD, {8'h00, OPC_QUERY});
  endtask : query

  // poll alternate status, which leaves a pending interrupt alone
  task automatic wait_drq(output logic ok, output logic [15:0] st);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(ADDR_DEV_CTL, st);
      ok = st[ST_DRQ_BIT];
    end
  endtask : wait_drq
endmodule : atair_host_model

// ---- test/atair_responder_tb_top.sv ----
`timescale 1ns/1ps
module atair_responder_tb_top
  import atair_pkg::*;
();
  logic        ref_clk;
  logic        reset_n;
  logic [3:0]  addr;
  logic [15:0] wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rd_data;
  atair_cfg_t  cfg;
  logic        unit_select;
  logic        host_irq;
  atair_cmd_t  cmd_out;
  logic [15:0] exp_q [256];
  logic [15:0] msk_q [256];
  logic [7:0]  cmd_q [$];
  logic [7:0]  ops [4] = '{8'h20, 8'h91, 8'hef, 8'h00};
  logic [15:0] st;
  int          bad_count;
  int          comparisons;

  atair_responder DUT (
    .ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .cfg(cfg), .unit_select(unit_select),
    .host_irq(host_irq), .cmd_out(cmd_out));
  atair_host_model host (
    .ref_clk(ref_clk), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data));

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // collect forwarded commands while their pulse stands
  always @(posedge ref_clk) begin
    if (cmd_out.valid === 1'b1) cmd_q.push_back(cmd_out.opcode);
  end

  // ********************
  // model and checks
  // ********************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input logic [15:0] msk);
    comparisons++;
    if ((got & msk) !== (exp & msk)) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // new settings and the block they should produce
  task automatic new_cfg();
    atair_cfg_t  c;
    logic [31:0] cap;
    for (int i = 0; i < 26; i++) c = {c, $urandom};
    c.serial_user = {10{8'h20}}; // user part left as spaces
    for (int i = 0; i < 10; i++)
      c.unique_id[8*i +: 8] = 8'h30 + 8'($urandom_range(9));
    for (int i = 0; i < 40; i++)
      c.model[8*i +: 8] = 8'h41 + 8'($urandom_range(25));
    c.fw_rev = c.model[63:0];
    cfg <= c;
    cap = c.cur_cyl * c.cur_heads;
    cap = cap * c.cur_spt;
    foreach (exp_q[i]) begin
      exp_q[i] = ZERO_WORD;
      msk_q[i] = 16'hffff;
    end
    {exp_q[85], exp_q[86], exp_q[87]} = c.feat_enabled;
    {exp_q[89], exp_q[90]} = {c.erase_time, c.erase_time_enh};
    exp_q[128] = c.security_status;
    exp_q[0] = W_GEN_CFG;
    exp_q[1] = c.def_cyl;
    exp_q[3] = c.def_heads;
    exp_q[6] = c.def_spt;
    {exp_q[7], exp_q[8]} = c.total_sectors;
    for (int i = 0; i < 5; i++) begin
      exp_q[10+i] = c.serial_user[79-16*i -: 16];
      exp_q[15+i] = c.unique_id[79-16*i -: 16];
    end
    for (int i = 0; i < 4; i++) exp_q[23+i] = c.fw_rev[63-16*i -: 16];
    for (int i = 0; i < 20; i++) exp_q[27+i] = c.model[319-16*i -: 16];
    exp_q[20] = W_BUF_TYPE;
    exp_q[47] = W_MULTI_MAX;
    exp_q[49] = W_CAPS;
    exp_q[51] = W_PIO_MODE;
    exp_q[53] = W_VALID;
    {exp_q[54], exp_q[55], exp_q[56]} = {c.cur_cyl, c.cur_heads, c.cur_spt};
    {exp_q[58], exp_q[57]} = cap;
    exp_q[59] = {W_MULTI_FLAG, c.multi_count};
    {exp_q[61], exp_q[60]} = c.total_sectors;
    exp_q[63] = {c.dma_select, W_DMA_SUPP};
    exp_q[64] = W_ADV_PIO;
    for (int i = 65; i < 69; i++) exp_q[i] = W_CYCLE_TIME;
    {exp_q[80], exp_q[81], exp_q[82]} = {W_MAJOR_VER, W_MINOR_VER, W_FEAT_82};
    {exp_q[83], exp_q[84]} = {W_FEAT_83, W_FEAT_84};
    exp_q[88] = {c.udma_select, W_UDMA_SUPP};
    exp_q[163] = {c.adv_timing, W_TIMING_LOW};
  endtask : new_cfg

  // one query with noise in the ignored registers, n words read back
  task automatic run_query(input int n, input logic masked);
    logic        ok;
    logic [15:0] s;
    for (int r = 1; r < 6; r++) host.wr(4'(r), 16'($urandom));
    host.query(unit_select);
    host.rd(ADDR_CMD, s);
    chk(s, 16'h0080, 16'hffff);
    host.wait_drq(ok, s);
    chk({15'h0, ok}, 16'h0001, 16'hffff);
    if (!ok) test_done();
    chk(s, 16'h0058, 16'hffff);
    chk({15'h0, host_irq}, {15'h0, !masked}, 16'hffff);
    host.rd(ADDR_CMD, s);
    repeat (2) @(posedge ref_clk);
    chk({15'h0, host_irq}, ZERO_WORD, 16'hffff);
    for (int i = 0; i < n; i++) begin
      host.rd(ADDR_DATA, s);
      chk(s, exp_q[i], msk_q[i]);
    end
  endtask : run_query

  // ********************
  // main sequence
  // ********************
  initial begin
    bad_count = 0;
    comparisons = 0;
    reset_n = 1'b0;
    cfg = '0;
    unit_select = 1'b0;
    void'($urandom(32'h2aa9006c));
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    unit_select <= 1'b1;
    @(posedge ref_clk);
    host.rd(ADDR_CMD, st);
    chk(st, 16'h0050, 16'hffff);
    host.rd(ADDR_SUBCMD, st);
    chk(st, ZERO_WORD, 16'hffff);
    host.rd(4'h9, st);
    chk(st, ZERO_WORD, 16'hffff);
    new_cfg();
    host.query(1'b0);
    host.rd(ADDR_CMD, st);
    chk(st, 16'h0050, 16'hffff);
    host.wr(ADDR_UNIT_HD, 16'h00ba);
    foreach (ops[k]) host.wr(ADDR_CMD, {8'h00, ops[k]});
    // the last pulse is collected at the edge the write task returns on
    @(posedge ref_clk);
    chk(16'(cmd_q.size()), 16'h0004, 16'hffff);
    foreach (ops[k]) chk({8'h00, cmd_q.pop_front()}, {8'h00, ops[k]},
                         16'hffff);
    run_query(256, 1'b0);
    host.rd(ADDR_CMD, st);
    chk(st, 16'h0050, 16'hffff);
    host.rd(ADDR_DATA, st);
    chk(st, ZERO_WORD, 16'hffff);
    new_cfg();
    host.wr(ADDR_DEV_CTL, 16'h0002);
    run_query(10, 1'b1);
    host.wr(ADDR_DEV_CTL, 16'h0004);
    host.rd(ADDR_CMD, st);
    chk(st, 16'h0080, 16'h0080);
    host.wr(ADDR_DEV_CTL, 16'h0000);
    host.rd(ADDR_CMD, st);
    chk(st, 16'h0050, 16'hffff);
    new_cfg();
    run_query(256, 1'b0);
    chk(16'(cmd_q.size()), ZERO_WORD, 16'hffff);
    test_done();
  end
endmodule : atair_responder_tb_top

// ---- verilog/atair_responder.sv ----
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module atair_responder
  import atair_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // task file port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rd_data,
  // product settings, same clock domain
  input  wire atair_cfg_t  cfg,
  input  wire logic        unit_select,
  // to the host and the rest of the device
  output logic             host_irq,
  output atair_cmd_t       cmd_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  atair_state_t state_reg;
  logic [7:0]   subcmd_reg;
  logic [7:0]   xfer_cnt_reg;
  logic [7:0]   start_sn_reg;
  logic [7:0]   trk_lo_reg;
  logic [7:0]   trk_hi_reg;
  logic [7:0]   unit_hd_reg;
  logic [7:0]   error_reg;
  logic         srst_reg;
  logic         nien_reg;
  logic         busy_reg;
  logic         drq_reg;
  logic         irq_pend_reg;
  logic [3:0]   prep_cnt_reg;
  logic [7:0]   idx_reg;
  logic [31:0]  cap_reg;
  logic [15:0]  rd_data_reg;
  logic         host_irq_reg;
  atair_cmd_t   cmd_out_reg;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic       unit_hit;
  logic       cmd_wr;
  logic       query_go;
  logic       other_go;
  logic       data_rd;
  logic       last_rd;
  logic       status_rd;
  logic       prep_done;
  logic [7:0] status;

  // only the drive bit selects us; head bits are never looked at
  assign unit_hit  = unit_hd_reg[UH_DRIVE_BIT] == unit_select;
  assign cmd_wr    = wr_stb && addr == ADDR_CMD && unit_hit
                     && !busy_reg && !drq_reg && !srst_reg;
  assign query_go  = cmd_wr && wr_data[7:0] == OPC_QUERY;
  assign other_go  = cmd_wr && wr_data[7:0] != OPC_QUERY;
  assign data_rd   = rd_stb && addr == ADDR_DATA && drq_reg;
  assign last_rd   = data_rd && idx_reg == LAST_WORD;
  assign status_rd = rd_stb && addr == ADDR_CMD;
  assign prep_done = state_reg == ST_PREP && prep_cnt_reg == PREP_LAST;

  // status byte; ready and seek complete whenever not busy
  always_comb begin
    status              = 8'h00;
    status[ST_BSY_BIT]  = busy_reg;
    status[ST_DRDY_BIT] = !busy_reg;
    status[ST_DSC_BIT]  = !busy_reg;
    status[ST_DRQ_BIT]  = drq_reg;
    status[ST_ERR_BIT]  = error_reg != 8'h00;
  end

  // ****************************************************************
  // task file registers
  // ****************************************************************
  // the query reads only the drive bit of these; the rest are held for other
  // commands, and all but the subcommand, which reads as error, read back unchanged
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      subcmd_reg   <= 8'h00;
      xfer_cnt_reg <= 8'h01;
      start_sn_reg <= 8'h01;
      trk_lo_reg   <= 8'h00;
      trk_hi_reg   <= 8'h00;
      unit_hd_reg  <= 8'h00;
    end else if (wr_stb) begin
      case (addr)
        ADDR_SUBCMD:   subcmd_reg   <= wr_data[7:0];
        ADDR_XFER_CNT: xfer_cnt_reg <= wr_data[7:0];
        ADDR_START_SN: start_sn_reg <= wr_data[7:0];
        ADDR_TRK_LO:   trk_lo_reg   <= wr_data[7:0];
        ADDR_TRK_HI:   trk_hi_reg   <= wr_data[7:0];
        ADDR_UNIT_HD:  unit_hd_reg  <= wr_data[7:0];
        default: ;
      endcase
    end
  end

  // device control: software reset and interrupt disable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      srst_reg <= 1'b0;
      nien_reg <= 1'b0;
    end else if (wr_stb && addr == ADDR_DEV_CTL) begin
      srst_reg <= wr_data[DC_SRST_BIT];
      nien_reg <= wr_data[DC_NIEN_BIT];
    end
  end

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  // busy rises on the query write edge itself, no queueing delay
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= ST_IDLE;
      busy_reg     <= 1'b0;
      drq_reg      <= 1'b0;
      prep_cnt_reg <= 4'h0;
      idx_reg      <= 8'h00;
    end else if (srst_reg) begin
      state_reg    <= ST_IDLE;
      busy_reg     <= 1'b1;  // busy for as long as reset is held
      drq_reg      <= 1'b0;
      prep_cnt_reg <= 4'h0;
      idx_reg      <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          busy_reg <= 1'b0;
          if (query_go) begin
            state_reg    <= ST_PREP;
            busy_reg     <= 1'b1;
            prep_cnt_reg <= 4'h0;
            idx_reg      <= 8'h00;
          end
        end
        ST_PREP: begin
          prep_cnt_reg <= prep_cnt_reg + 4'h1;
          if (prep_done) begin
            state_reg <= ST_XFER;
            busy_reg  <= 1'b0;
            drq_reg   <= 1'b1;
          end
        end
        ST_XFER: begin
          if (data_rd) begin
            idx_reg <= idx_reg + 8'h01;
          end
          if (last_rd) begin
            state_reg <= ST_IDLE;
            drq_reg   <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_reg  <= 1'b0;
          drq_reg   <= 1'b0;
        end
      endcase
    end
  end

  // error register; the query never fails, a new command clears it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_reg <= 8'h00;
    end else if (srst_reg || cmd_wr) begin
      error_reg <= 8'h00;
    end
  end

  // ****************************************************************
  // interrupt
  // ****************************************************************
  // one interrupt per sector: raised with the data request; a status
  // read in the same cycle loses to the set
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pend_reg <= 1'b0;
    end else if (srst_reg) begin
      irq_pend_reg <= 1'b0;
    end else if (prep_done) begin
      irq_pend_reg <= 1'b1;
    end else if (status_rd || cmd_wr) begin
      irq_pend_reg <= 1'b0;
    end
  end

  // pin follows the pending flag one cycle late, masked by disable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_irq_reg <= 1'b0;
    end else begin
      host_irq_reg <= irq_pend_reg && !nien_reg;
    end
  end

  // ****************************************************************
  // other commands handed on
  // ****************************************************************
  // executing them is left to the rest of the device
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_out_reg <= '0;
    end else begin
      cmd_out_reg.valid  <= other_go;
      cmd_out_reg.opcode <= other_go ? wr_data[7:0] : 8'h00;
    end
  end

  // ****************************************************************
  // parameter block
  // ****************************************************************
  // capacity registered to keep the multiplier off the read path;
  // settles well inside the busy time
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_reg <= 32'h0000_0000;
    end else begin
      cap_reg <= 32'(cfg.cur_cyl) * cfg.cur_heads * cfg.cur_spt;
    end
  end

  logic [15:0] w_user;
  logic [15:0] w_uid;
  logic [15:0] w_fw;
  logic [15:0] w_model;
  logic [15:0] word;

  // serial, user part, right justified and space padded by owner
  atair_str_word #(.NW(5)) u_user (
    .str  (cfg.serial_user),
    .idx  (idx_reg),
    .base (8'd10),
    .word (w_user)
  );

  // serial, factory unique part
  atair_str_word #(.NW(5)) u_uid (
    .str  (cfg.unique_id),
    .idx  (idx_reg),
    .base (8'd15),
    .word (w_uid)
  );

  // firmware revision
  atair_str_word #(.NW(4)) u_fw (
    .str  (cfg.fw_rev),
    .idx  (idx_reg),
    .base (8'd23),
    .word (w_fw)
  );

  // model string
  atair_str_word #(.NW(20)) u_model (
    .str  (cfg.model),
    .idx  (idx_reg),
    .base (8'd27),
    .word (w_model)
  );

  // word table; anything not named reads zero
  always_comb begin
    word = ZERO_WORD;
    case (idx_reg) inside
      8'd0:   word = W_GEN_CFG;
      8'd1:   word = cfg.def_cyl;
      8'd3:   word = cfg.def_heads;
      8'd6:   word = cfg.def_spt;
      8'd7:   word = cfg.total_sectors[31:16];
      8'd8:   word = cfg.total_sectors[15:0];
      [8'd10:8'd14]: word = w_user;
      [8'd15:8'd19]: word = w_uid;
      8'd20:  word = W_BUF_TYPE;
      [8'd23:8'd26]: word = w_fw;
      [8'd27:8'd46]: word = w_model;
      8'd47:  word = W_MULTI_MAX;
      8'd49:  word = W_CAPS;
      8'd51:  word = W_PIO_MODE;
      8'd53:  word = W_VALID;
      8'd54:  word = cfg.cur_cyl;
      8'd55:  word = cfg.cur_heads;
      8'd56:  word = cfg.cur_spt;
      8'd57:  word = cap_reg[15:0];
      8'd58:  word = cap_reg[31:16];
      8'd59:  word = {W_MULTI_FLAG, cfg.multi_count};
      8'd60:  word = cfg.total_sectors[15:0];
      8'd61:  word = cfg.total_sectors[31:16];
      8'd63:  word = {cfg.dma_select, W_DMA_SUPP};
      8'd64:  word = W_ADV_PIO;
      [8'd65:8'd68]: word = W_CYCLE_TIME;
      8'd80:  word = W_MAJOR_VER;
      8'd81:  word = W_MINOR_VER;
      8'd82:  word = W_FEAT_82;
      8'd83:  word = W_FEAT_83;
      8'd84:  word = W_FEAT_84;
      8'd85:  word = cfg.feat_enabled[47:32];
      8'd86:  word = cfg.feat_enabled[31:16];
      8'd87:  word = cfg.feat_enabled[15:0];
      8'd88:  word = {cfg.udma_select, W_UDMA_SUPP};
      8'd89:  word = cfg.erase_time;
      8'd90:  word = cfg.erase_time_enh;
      8'd128: word = cfg.security_status;
      8'd163: word = {cfg.adv_timing, W_TIMING_LOW};
      default: word = ZERO_WORD;
    endcase
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // data valid only in the cycle after the strobe; data port outside
  // a transfer reads zero rather than stale words
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg <= 16'h0000;
    end else if (rd_stb) begin
      case (addr)
        ADDR_DATA:     rd_data_reg <= data_rd ? word : ZERO_WORD;
        ADDR_SUBCMD:   rd_data_reg <= {8'h00, error_reg};
        ADDR_XFER_CNT: rd_data_reg <= {8'h00, xfer_cnt_reg};
        ADDR_START_SN: rd_data_reg <= {8'h00, start_sn_reg};
        ADDR_TRK_LO:   rd_data_reg <= {8'h00, trk_lo_reg};
        ADDR_TRK_HI:   rd_data_reg <= {8'h00, trk_hi_reg};
        ADDR_UNIT_HD:  rd_data_reg <= {8'h00, unit_hd_reg};
        ADDR_CMD:      rd_data_reg <= {8'h00, status};
        ADDR_DEV_CTL:  rd_data_reg <= {8'h00, status};
        default:       rd_data_reg <= ZERO_WORD;
      endcase
    end else begin
      rd_data_reg <= ZERO_WORD;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rd_data  = rd_data_reg;
  assign host_irq = host_irq_reg;
  assign cmd_out  = cmd_out_reg;

endmodule : atair_responder

// ---- verilog/atair_str_word.sv ----
`timescale 1ns/1ps
// picks one 16-bit word of an ascii string, first character at the msb
module atair_str_word
  import atair_pkg::*;
#(
  parameter int NW = 5
) (
  // string and position
  input  wire logic [NW*16-1:0] str,
  input  wire logic [7:0]       idx,
  input  wire logic [7:0]       base,
  // selected word
  output logic      [15:0]      word
);

  logic [7:0] rel;

  // out of range yields zero so the caller can or the results freely
  always_comb begin
    rel  = 8'(idx - base);
    word = ZERO_WORD;
    if (idx >= base && int'(rel) < NW) begin
      word = str[(NW - 1 - int'(rel)) * 16 +: 16];
    end
  end

endmodule : atair_str_word
